// [common/rcc_gate_pkg.sv]
package rcc_gate_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] OFS_OSC_IRQ = 8'h08;
    localparam logic [7:0] OFS_B_RST   = 8'h0C;
    localparam logic [7:0] OFS_A_RST   = 8'h10;
    localparam logic [7:0] OFS_MAIN_EN = 8'h14;
    localparam logic [7:0] OFS_B_EN    = 8'h18;
    localparam logic [7:0] OFS_A_EN    = 8'h1C;
    // ==========================================
    // implemented bits and reset values
    localparam logic [31:0] MASK_B    = 32'h0047_DA01;
    localparam logic [31:0] MASK_A    = 32'h1022_4803;
    localparam logic [31:0] MASK_MAIN = 32'h041E_0055;
    localparam logic [31:0] RST_B     = 32'h0000_0000;
    localparam logic [31:0] RST_A     = 32'h0000_0000;
    localparam logic [31:0] RST_MAIN  = 32'h0000_0014;
    // ==========================================
    // field positions
    localparam int SLOW_FLAG_BIT = 0;
    localparam int FAST_FLAG_BIT = 2;
    localparam int SLOW_IE_BIT   = 8;
    localparam int FAST_IE_BIT   = 10;
    localparam int SLOW_CLR_BIT  = 16;
    localparam int FAST_CLR_BIT  = 18;
    localparam int SRAM_EN_BIT   = 2;
    localparam int PWR_EN_BIT    = 28;
    // ==========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // types
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP    = 1'b1
    } wr_state_t;
    typedef struct packed {
        logic fast_ie;
        logic slow_ie;
        logic fast_flag;
        logic slow_flag;
    } osc_irq_t;
    typedef struct packed {
        logic [31:0] b_rst;
        logic [31:0] a_rst;
        logic [31:0] main_en;
        logic [31:0] b_en;
        logic [31:0] a_en;
    } gate_regs_t;
endpackage : rcc_gate_pkg

// [rtl/periph_reset_clock_gating.sv]
// How it works
// - fast oscillator ready flag, bit 2, sets on stabilising when enabled
// - writing 1 to fast clear bit clears that flag; otherwise read-only
// - slow 40 kHz oscillator ready flag, bit 0, sets when enabled
// - writing 1 to slow clear bit clears flag; writing 0 does nothing
// - bus B reset register at 0x0C, resets to zero, 1 resets peripheral
// - B reset bits 18,17,16,11 timers; bit 22 debug support unit
// - B reset bits 15,14,12,9,0: comparator, serial, sync, converter, config
// - bus A reset register at 0x10; bit 28 power, bit 21 two-wire
// - A reset bits 17,14,11,1,0: serial, sync, watchdog, timers three, two
// - main clock enable at 0x14 resets to 0x14: flash, memory on
// - main enable bits 26, 20..17, 6, 0: divider, ports, checksum, transfer
// - main bit 2 keeps memory clock in sleep when 1, stops when 0
// - bus B clock enable at 0x18, zero reset, same bits as reset
// - bus B peripheral reads unreliable while its clock is off; gated reads return zero
// - bus A clock enable at 0x1C, zero reset; gated reads return zero
// - A enable bit 28 gates the power interface clock
// - word, half-word and byte access without wait states
// - A enable bits 21,17,14,11,1,0 gate the bus A peripherals
`timescale 1ns/1ns
module periph_reset_clock_gating
    import rcc_gate_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sleep_mode,
    input  wire logic              fast_osc_stable,
    input  wire logic              slow_osc_stable,
    output logic [31:0]            b_periph_reset,
    output logic [31:0]            a_periph_reset,
    output logic [31:0]            main_clk_out,
    output logic [31:0]            b_clk_out,
    output logic [31:0]            a_clk_out,
    input  wire logic [31:0]       b_sel,
    input  wire logic [31:0]       b_rdata_in,
    output logic [31:0]            b_rdata_out,
    input  wire logic [31:0]       a_sel,
    input  wire logic [31:0]       a_rdata_in,
    output logic [31:0]            a_rdata_out
);
    if (ADDR_W < 8) begin : g_addr_w_check
        $error("ADDR_W too small for the register map");
    end

    // ==========================================
    // state
    wr_state_t         wst_q;
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [7:0]        waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    gate_regs_t        regs_q;
    osc_irq_t          irq_q;
    logic [1:0]        osc_meta_q;
    logic [1:0]        osc_sync_q;
    logic [1:0]        osc_prev_q;
    logic [31:0]       gate_main_q;
    logic [31:0]       gate_b_q;
    logic [31:0]       gate_a_q;
    logic [95:0]       gate_seen_q;
    logic              wr_do;
    logic [1:0]        osc_rise;
    logic              fast_set;
    logic              slow_set;
    logic              fast_clr;
    logic              slow_clr;
    logic [31:0]       main_want;
    logic [7:0]        raddr;
    logic [7:0]        rd_addr;

    // ==========================================
    // byte-lane merge
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb,
        input logic [31:0] mask
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r & mask;
    endfunction : merge

    // ==========================================
    // write channel
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = (wst_q == WR_RESP);
    assign s_axi_bresp   = bresp_q;
    assign wr_do = ce && (wst_q == WR_COLLECT) && aw_hold_q && w_hold_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            waddr_q   <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                waddr_q   <= {s_axi_awaddr[7:2], 2'b00};
            end else if (s_axi_bready && wst_q == WR_RESP) begin
                aw_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (s_axi_bready && wst_q == WR_RESP) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q   <= WR_COLLECT;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            case (wst_q)
                WR_COLLECT: begin
                    if (wr_do) begin
                        wst_q <= WR_RESP;
                        if (waddr_q == OFS_OSC_IRQ || (waddr_q >= OFS_B_RST
                                && waddr_q <= OFS_A_EN)) begin
                            bresp_q <= RESP_OKAY;
                        end else begin
                            bresp_q <= RESP_SLVERR;
                        end
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wst_q <= WR_COLLECT;
                    end
                end
                default: wst_q <= WR_COLLECT;
            endcase
        end
    end

    // ==========================================
    // reset and clock enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_q.b_rst   <= RST_B;
            regs_q.a_rst   <= RST_A;
            regs_q.main_en <= RST_MAIN;
            regs_q.b_en    <= RST_B;
            regs_q.a_en    <= RST_A;
        end else if (wr_do) begin
            if (waddr_q == OFS_B_RST) begin
                regs_q.b_rst <= merge(regs_q.b_rst, wdata_q, wstrb_q, MASK_B);
            end else if (waddr_q == OFS_A_RST) begin
                regs_q.a_rst <= merge(regs_q.a_rst, wdata_q, wstrb_q, MASK_A);
            end else if (waddr_q == OFS_MAIN_EN) begin
                regs_q.main_en <= merge(regs_q.main_en, wdata_q, wstrb_q,
                                        MASK_MAIN);
            end else if (waddr_q == OFS_B_EN) begin
                regs_q.b_en <= merge(regs_q.b_en, wdata_q, wstrb_q, MASK_B);
            end else if (waddr_q == OFS_A_EN) begin
                regs_q.a_en <= merge(regs_q.a_en, wdata_q, wstrb_q, MASK_A);
            end
        end
    end

    // held resets, no self-clear
    assign b_periph_reset = regs_q.b_rst;
    assign a_periph_reset = regs_q.a_rst;

    // ==========================================
    // oscillator ready synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_meta_q <= 2'b00;
            osc_sync_q <= 2'b00;
            osc_prev_q <= 2'b00;
        end else if (ce) begin
            osc_meta_q <= {fast_osc_stable, slow_osc_stable};
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    assign osc_rise = osc_sync_q & ~osc_prev_q;
    assign fast_set = osc_rise[1] && irq_q.fast_ie;
    assign slow_set = osc_rise[0] && irq_q.slow_ie;
    assign fast_clr = wr_do && waddr_q == OFS_OSC_IRQ && wstrb_q[FAST_CLR_BIT/8]
                      && wdata_q[FAST_CLR_BIT];
    assign slow_clr = wr_do && waddr_q == OFS_OSC_IRQ && wstrb_q[SLOW_CLR_BIT/8]
                      && wdata_q[SLOW_CLR_BIT];

    // ==========================================
    // ready flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= '0;
        end else if (ce) begin
            irq_q.fast_flag <= fast_set || (irq_q.fast_flag && !fast_clr);
            irq_q.slow_flag <= slow_set || (irq_q.slow_flag && !slow_clr);
            if (wr_do && waddr_q == OFS_OSC_IRQ && wstrb_q[1]) begin
                irq_q.fast_ie <= wdata_q[FAST_IE_BIT];
                irq_q.slow_ie <= wdata_q[SLOW_IE_BIT];
            end
        end
    end

    // ==========================================
    // clock gates, enables move on the falling edge
    always_comb begin
        main_want = regs_q.main_en & MASK_MAIN;
        main_want[SRAM_EN_BIT] = regs_q.main_en[SRAM_EN_BIT] || !sleep_mode;
    end

    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            gate_main_q <= RST_MAIN;
            gate_b_q    <= RST_B;
            gate_a_q    <= RST_A;
        end else if (ce) begin
            gate_main_q <= main_want;
            gate_b_q    <= regs_q.b_en;
            gate_a_q    <= regs_q.a_en;
        end
    end

    assign main_clk_out = {32{aclk}} & gate_main_q;
    assign b_clk_out    = {32{aclk}} & gate_b_q;
    assign a_clk_out    = {32{aclk}} & gate_a_q;

    // gate value seen at each rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_seen_q <= {RST_MAIN, RST_B, RST_A};
        end else if (ce) begin
            gate_seen_q <= {gate_main_q, gate_b_q, gate_a_q};
        end
    end

    // ==========================================
    // read-back gating for stopped peripherals
    assign b_rdata_out = |(b_sel & gate_b_q) ? b_rdata_in : 32'h0000_0000;
    assign a_rdata_out = |(a_sel & gate_a_q) ? a_rdata_in : 32'h0000_0000;

    // ==========================================
    // read channel
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign raddr         = s_axi_araddr[7:0];
    assign rd_addr       = {raddr[7:2], 2'b00};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OKAY;
                rdata_q  <= 32'h0000_0000;
                if (rd_addr == OFS_OSC_IRQ) begin
                    rdata_q[FAST_IE_BIT]   <= irq_q.fast_ie;
                    rdata_q[SLOW_IE_BIT]   <= irq_q.slow_ie;
                    rdata_q[FAST_FLAG_BIT] <= irq_q.fast_flag;
                    rdata_q[SLOW_FLAG_BIT] <= irq_q.slow_flag;
                end else if (rd_addr == OFS_B_RST) begin
                    rdata_q <= regs_q.b_rst;
                end else if (rd_addr == OFS_A_RST) begin
                    rdata_q <= regs_q.a_rst;
                end else if (rd_addr == OFS_MAIN_EN) begin
                    rdata_q <= regs_q.main_en;
                end else if (rd_addr == OFS_B_EN) begin
                    rdata_q <= regs_q.b_en;
                end else if (rd_addr == OFS_A_EN) begin
                    rdata_q <= regs_q.a_en;
                end else begin
                    rresp_q <= RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // checks
    sequence fast_event_s;
        ce && fast_set;
    endsequence

    sequence write_both_s;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !aw_hold_q && !w_hold_q;
    endsequence

    chk_fast_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        fast_event_s |=> irq_q.fast_flag)
        else $error("fast ready flag not set");
    chk_fast_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        fast_clr && !fast_set |=> !irq_q.fast_flag)
        else $error("fast ready flag not cleared");
    chk_slow_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && osc_rise[0] && irq_q.slow_ie |=> irq_q.slow_flag)
        else $error("slow ready flag not set");
    chk_slow_zero_write: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && irq_q.slow_flag && !slow_clr |=> irq_q.slow_flag)
        else $error("slow ready flag lost");
    chk_b_reset_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        (b_periph_reset & ~MASK_B) == 32'h0000_0000)
        else $error("reserved bus B reset bit set");
    chk_write_no_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        write_both_s ##1 ce |=> s_axi_bvalid)
        else $error("write answer late");
    chk_reset_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_do |=> $stable(a_periph_reset) && $stable(b_periph_reset))
        else $error("peripheral reset changed without write");
    chk_sram_sleep: assert property (@(negedge aclk) disable iff (!aresetn)
        ce && sleep_mode && !regs_q.main_en[SRAM_EN_BIT]
            |=> !gate_main_q[SRAM_EN_BIT])
        else $error("memory clock runs in sleep");
    chk_gate_stable_high: assert property (@(negedge aclk) disable iff (!aresetn)
        {gate_main_q, gate_b_q, gate_a_q} == gate_seen_q)
        else $error("gate enable moved while clock high");
    chk_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (a_sel & gate_a_q) == 32'h0000_0000 |-> a_rdata_out == 32'h0000_0000)
        else $error("stopped peripheral read not zero");
    chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_b_gate_follow: assert property (@(negedge aclk) disable iff (!aresetn)
        ce |=> gate_b_q == $past(regs_q.b_en))
        else $error("bus B gate not following register");
endmodule : periph_reset_clock_gating

// [verif/periph_reset_clock_gating_tb_top.sv]
`timescale 1ns/1ns
module periph_reset_clock_gating_tb_top;
    import rcc_gate_pkg::*;
    logic        aclk, aresetn, ce, sleep_mode, fast_on, slow_on, fast_osc_stable;
    logic        slow_osc_stable, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, b_periph_reset, a_periph_reset, main_clk_out;
    logic [31:0] b_clk_out, a_clk_out, b_sel, a_sel, b_rdata_in, a_rdata_in;
    logic [31:0] b_rdata_out, a_rdata_out;
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          rd_lat      = 0;
    logic [7:0]  ofs  [5] = '{OFS_B_RST, OFS_A_RST, OFS_MAIN_EN, OFS_B_EN, OFS_A_EN};
    logic [31:0] rstv [5] = '{RST_B, RST_A, RST_MAIN, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] mask [5] = '{MASK_B, MASK_A, MASK_MAIN, MASK_B, MASK_A};

    periph_reset_clock_gating #(.ADDR_W(8)) u_periph_reset_clock_gating (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleep_mode(sleep_mode),
        .fast_osc_stable(fast_osc_stable), .slow_osc_stable(slow_osc_stable),
        .b_periph_reset(b_periph_reset), .a_periph_reset(a_periph_reset),
        .main_clk_out(main_clk_out), .b_clk_out(b_clk_out), .a_clk_out(a_clk_out),
        .b_sel(b_sel), .b_rdata_in(b_rdata_in), .b_rdata_out(b_rdata_out),
        .a_sel(a_sel), .a_rdata_in(a_rdata_in), .a_rdata_out(a_rdata_out)
    );
    periph_side_model u_periph_side_model (
        .aclk(aclk), .fast_on(fast_on), .slow_on(slow_on),
        .fast_osc_stable(fast_osc_stable), .slow_osc_stable(slow_osc_stable),
        .b_sel(b_sel), .a_sel(a_sel), .b_rdata_in(b_rdata_in), .a_rdata_in(a_rdata_in)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ==========================================
    // verdict, comparisons and bus tasks
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic fail_hang();
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask : fail_hang
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask : chk_resp
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk_resp(s_axi_bresp, er);
                n = 1000;
            end
        end
        if (n < 1000) fail_hang();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_rvalid) begin
                chk_word(s_axi_rdata, exp);
                chk_resp(s_axi_rresp, er);
                rd_lat = n;
                n = 1000;
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                n = 0;
            end
        end
        if (n < 1000) fail_hang();
    endtask : rd
    task automatic chk_clk(input logic [31:0] m, input logic [31:0] b, input logic [31:0] a);
        @(posedge aclk);
        #2;
        chk_word(main_clk_out, m);
        chk_word(b_clk_out, b);
        chk_word(a_clk_out, a);
        #4;
        chk_word(main_clk_out | b_clk_out | a_clk_out, 32'h0000_0000);
        @(posedge aclk);
    endtask : chk_clk

    // ==========================================
    // main sequence
    initial begin
        int n;
        {aresetn, sleep_mode, fast_on, slow_on, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {ce, s_axi_bready, s_axi_rready} = 3'b111;
        b_sel = 32'h0000_0000;
        a_sel = 32'h0000_0000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(ofs[i], rstv[i], RESP_OKAY);
        rd(OFS_OSC_IRQ, 32'h0000_0000, RESP_OKAY);
        chk_word(b_periph_reset | a_periph_reset, 32'h0000_0000);
        chk_clk(RST_MAIN, 32'h0000_0000, 32'h0000_0000);
        chk_word(32'(rd_lat), 32'h0000_0001);
        for (int i = 0; i < 5; i++) wr(ofs[i], 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        for (int i = 0; i < 5; i++) rd(ofs[i], mask[i], RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk_word(b_periph_reset, MASK_B);
        chk_word(a_periph_reset, MASK_A);
        chk_clk(MASK_MAIN, MASK_B, MASK_A);
        wr(OFS_A_RST, 32'h0000_0000, 4'h8, RESP_OKAY);
        wr(OFS_B_RST, 32'h0000_0000, 4'h3, RESP_OKAY);
        rd(OFS_A_RST, MASK_A & 32'h00FF_FFFF, RESP_OKAY);
        rd(OFS_B_RST, MASK_B & 32'hFFFF_0000, RESP_OKAY);
        chk_word(a_periph_reset, MASK_A & 32'h00FF_FFFF);
        chk_word(b_periph_reset, MASK_B & 32'hFFFF_0000);
        // memory clock in and out of sleep
        wr(OFS_MAIN_EN, 32'h0000_0010, 4'hF, RESP_OKAY);
        chk_clk(32'h0000_0014, MASK_B, MASK_A);
        sleep_mode <= 1'b1;
        chk_clk(32'h0000_0010, MASK_B, MASK_A);
        wr(OFS_MAIN_EN, 32'h0000_0014, 4'h1, RESP_OKAY);
        chk_clk(32'h0000_0014, MASK_B, MASK_A);
        sleep_mode <= 1'b0;
        // read gating of disabled peripherals
        a_sel <= 32'h1000_0000;
        b_sel <= 32'h0040_0000;
        repeat (2) @(posedge aclk);
        chk_word(a_rdata_out, 32'h1000_0000 ^ 32'h3C3C_0000);
        chk_word(b_rdata_out, 32'h0040_0000 ^ 32'hC3C3_0000);
        wr(OFS_A_EN, 32'h0000_0000, 4'h8, RESP_OKAY);
        wr(OFS_B_EN, 32'h0000_0000, 4'h4, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk_word(a_rdata_out, 32'h0000_0000);
        chk_word(b_rdata_out, 32'h0000_0000);
        chk_clk(32'h0000_0014, MASK_B & 32'hFF00_FFFF, MASK_A & 32'h00FF_FFFF);
        wr(8'h20, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, RESP_SLVERR);
        // oscillator ready flags
        fast_on <= 1'b1;
        for (n = 0; n < 100 && !fast_osc_stable; n++) @(posedge aclk);
        if (n == 100) fail_hang();
        repeat (4) @(posedge aclk);
        rd(OFS_OSC_IRQ, 32'h0000_0000, RESP_OKAY);
        fast_on <= 1'b0;
        wr(OFS_OSC_IRQ, 32'h0000_0500, 4'hF, RESP_OKAY);
        fast_on <= 1'b1;
        slow_on <= 1'b1;
        for (n = 0; n < 100 && !slow_osc_stable; n++) @(posedge aclk);
        if (n == 100) fail_hang();
        repeat (4) @(posedge aclk);
        rd(OFS_OSC_IRQ, 32'h0000_0505, RESP_OKAY);
        wr(OFS_OSC_IRQ, 32'h0004_0500, 4'hF, RESP_OKAY);
        rd(OFS_OSC_IRQ, 32'h0000_0501, RESP_OKAY);
        wr(OFS_OSC_IRQ, 32'h0001_0505, 4'hF, RESP_OKAY);
        rd(OFS_OSC_IRQ, 32'h0000_0500, RESP_OKAY);
        // clock enable low freezes the gates
        wr(OFS_MAIN_EN, 32'h0000_0010, 4'h1, RESP_OKAY);
        ce         <= 1'b0;
        sleep_mode <= 1'b1;
        chk_clk(32'h0000_0014, MASK_B & 32'hFF00_FFFF, MASK_A & 32'h00FF_FFFF);
        ce <= 1'b1;
        chk_clk(32'h0000_0010, MASK_B & 32'hFF00_FFFF, MASK_A & 32'h00FF_FFFF);
        report_and_stop();
    end
endmodule : periph_reset_clock_gating_tb_top

// [verif/periph_side_model.sv]
`timescale 1ns/1ns
module periph_side_model #(
    parameter int FAST_SETTLE = 6,
    parameter int SLOW_SETTLE = 20
) (
    input  wire logic        aclk,
    input  wire logic        fast_on,
    input  wire logic        slow_on,
    output logic             fast_osc_stable,
    output logic             slow_osc_stable,
    input  wire logic [31:0] b_sel,
    input  wire logic [31:0] a_sel,
    output logic [31:0]      b_rdata_in,
    output logic [31:0]      a_rdata_in
);
    // ==========================================
    // oscillators settle some cycles after switch-on
    int          fast_cnt = 0;
    int          slow_cnt = 0;
    logic [31:0] idle_q   = 32'h0000_0000;
    always @(posedge aclk) begin
        fast_cnt <= fast_on ? fast_cnt + 1 : 0;
        slow_cnt <= slow_on ? slow_cnt + 1 : 0;
        idle_q   <= ~idle_q;
    end
    assign fast_osc_stable = (fast_cnt >= FAST_SETTLE);
    assign slow_osc_stable = (slow_cnt >= SLOW_SETTLE);
    // ==========================================
    // peripheral read data, toggling when nobody is selected
    assign b_rdata_in = (b_sel != 32'h0) ? (b_sel ^ 32'hC3C3_0000) : idle_q;
    assign a_rdata_in = (a_sel != 32'h0) ? (a_sel ^ 32'h3C3C_0000) : ~idle_q;
endmodule : periph_side_model
